// >>> rtl/sair_pkg.sv
// Package with constants and types for the serial audio input receiver
package sair_pkg;
  // ==========================================================
  // Framing formats
  typedef enum logic [1:0] {
    SAIR_FMT_STD = 2'h0,
    SAIR_FMT_LJ  = 2'h1,
    SAIR_FMT_RJ  = 2'h2
  } sair_fmt_t;

  // ==========================================================
  // Link geometry
  localparam int unsigned SAIR_BCLK_PER_FS   = 64;
  localparam int unsigned SAIR_SLOT_BITS     = SAIR_BCLK_PER_FS / 2;
  localparam int unsigned SAIR_WORD_BITS     = 24;
  localparam int unsigned SAIR_CNT_W         = 5;
  localparam logic [4:0]  SAIR_CNT_ZERO      = 5'h00;
  localparam logic [4:0]  SAIR_CNT_ONE       = 5'h01;
  localparam logic [4:0]  SAIR_CNT_MAX       = 5'h1F;
endpackage

// >>> rtl/sair_xfer_if.sv
// Interface carrying captured frames from link domain to system domain
`timescale 1ns/1ps
interface sair_xfer_if #(
  parameter int unsigned WORD_W = 24
);
  logic [WORD_W-1:0] left;
  logic [WORD_W-1:0] right;
  logic              tgl;
  modport src (output left, output right, output tgl);
  modport dst (input left, input right, input tgl);
endinterface

// >>> rtl/sair_link_rx.sv
// Link-domain shifter: captures left and right words on the bit clock
`timescale 1ns/1ps
module sair_link_rx
  import sair_pkg::*;
#(
  parameter int unsigned WORD_W = SAIR_WORD_BITS
) (
  // Link clock and reset
  input  wire logic      i_bclk,
  input  wire logic      i_rst_n,
  // Pins and format
  input  wire logic      i_lrclk,
  input  wire logic      i_sdata,
  input  wire sair_fmt_t i_fmt,
  // Frame output
  sair_xfer_if.src       xf
);
  typedef struct packed {
    logic                  ws_d;
    logic [SAIR_CNT_W-1:0] cnt;
    logic [WORD_W-1:0]     sh;
    logic [WORD_W-1:0]     left;
    logic [WORD_W-1:0]     right;
    logic                  have_l;
    logic                  tgl;
  } sair_lrx_t;

  localparam logic [SAIR_CNT_W-1:0] RJ_SKIP =
    SAIR_CNT_W'(SAIR_SLOT_BITS - WORD_W);

  sair_lrx_t st_ff;
  sair_lrx_t nxt_st;
  logic      edge_w;
  logic      is_left;
  logic      take;
  logic [SAIR_CNT_W-1:0] pos;

  // ==========================================================
  // Bit position and capture window
  always_comb begin
    nxt_st = st_ff;
    edge_w = i_lrclk != st_ff.ws_d;
    // Standard: low is left; justified: high is left
    is_left = (i_fmt == SAIR_FMT_STD) ? !i_lrclk : i_lrclk; // R1 R2
    pos = edge_w ? SAIR_CNT_ZERO : st_ff.cnt + SAIR_CNT_ONE; // R3
    unique case (i_fmt)
      SAIR_FMT_STD: begin
        take = (pos >= SAIR_CNT_ONE) &&
               (pos <= SAIR_CNT_W'(WORD_W)); // R4 R7
      end
      SAIR_FMT_RJ: begin
        take = (pos >= RJ_SKIP); // R8 R9 R10
      end
      default: begin
        take = (pos < SAIR_CNT_W'(WORD_W)); // R6 R7
      end
    endcase
    nxt_st.ws_d = i_lrclk;
    nxt_st.cnt  = pos;
    if (take) begin
      nxt_st.sh = {st_ff.sh[WORD_W-2:0], i_sdata}; // R5
    end
    // Slot done at last bit of slot; word is complete
    if (pos == SAIR_CNT_MAX) begin
      if (is_left) begin
        nxt_st.left   = take ? nxt_st.sh : st_ff.sh;
        nxt_st.have_l = 1'b1;
      end else if (st_ff.have_l) begin
        nxt_st.right  = take ? nxt_st.sh : st_ff.sh;
        nxt_st.have_l = 1'b0;
        nxt_st.tgl    = !st_ff.tgl; // R11
      end
    end
  end

  always_ff @(posedge i_bclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign xf.left  = st_ff.left;
  assign xf.right = st_ff.right;
  assign xf.tgl   = st_ff.tgl;

  // ==========================================================
  // Checks
  property p_cnt_wrap;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (st_ff.cnt == SAIR_CNT_MAX && i_lrclk == st_ff.ws_d)
      |=> st_ff.cnt == SAIR_CNT_ZERO;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) // R3
    else $error("slot counter did not wrap");

  property p_cnt_edge;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (i_lrclk != st_ff.ws_d) |=> st_ff.cnt == SAIR_CNT_ZERO;
  endproperty
  a_cnt_edge: assert property (p_cnt_edge) // R4
    else $error("slot counter not restarted on word select edge");

  property p_std_mask;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (i_fmt == SAIR_FMT_STD && i_lrclk == st_ff.ws_d &&
     st_ff.cnt >= SAIR_CNT_W'(WORD_W)) |=> $stable(st_ff.sh);
  endproperty
  a_std_mask: assert property (p_std_mask) // R7
    else $error("trailing bit shifted in standard framing");

  property p_rj_mask;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (i_fmt == SAIR_FMT_RJ && i_lrclk != st_ff.ws_d) |=> $stable(st_ff.sh);
  endproperty
  a_rj_mask: assert property (p_rj_mask) // R10
    else $error("leading bit shifted in right-justified framing");

  property p_lj_first;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (i_fmt == SAIR_FMT_LJ && i_lrclk != st_ff.ws_d)
      |=> st_ff.sh[0] == $past(i_sdata);
  endproperty
  a_lj_first: assert property (p_lj_first) // R6
    else $error("left-justified MSB not taken at toggle");

  property p_rj_last;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (i_fmt == SAIR_FMT_RJ && st_ff.cnt == 5'h1E &&
     i_lrclk == st_ff.ws_d) |=> st_ff.sh[0] == $past(i_sdata);
  endproperty
  a_rj_last: assert property (p_rj_last) // R9
    else $error("right-justified LSB not taken in last slot bit");

  property p_shift;
    @(posedge i_bclk) disable iff (!i_rst_n)
    (i_fmt == SAIR_FMT_STD && i_lrclk == st_ff.ws_d &&
     st_ff.cnt == SAIR_CNT_ZERO)
      |=> st_ff.sh == {$past(st_ff.sh[WORD_W-2:0]), $past(i_sdata)};
  endproperty
  a_shift: assert property (p_shift) // R5
    else $error("bit not shifted in MSB first");

  c_frame: cover property (@(posedge i_bclk) disable iff (!i_rst_n)
    $changed(st_ff.tgl));
  c_rj: cover property (@(posedge i_bclk) disable iff (!i_rst_n)
    i_fmt == SAIR_FMT_RJ && $changed(st_ff.tgl));
  c_lj: cover property (@(posedge i_bclk) disable iff (!i_rst_n)
    i_fmt == SAIR_FMT_LJ && $changed(st_ff.tgl));
endmodule

// >>> rtl/sair_receiver.sv
// Serial audio input receiver top: link capture and system-side handover
// Overview of operation
// R1: Standard framing: word select low is left, high is right.
// R2: Justified framings: word select high is left, low is right.
// R3: Bit clock is 64 times sample rate, 32 bits per channel.
// R4: Standard framing: first bit one bit clock after word select edge.
// R5: Words arrive MSB first, captured on rising bit clock edge.
// R6: Left-justified: MSB sits in the bit period of the toggle.
// R7: Standard and left-justified: trailing bits after the word are ignored.
// R8: Right-justified 24-bit: data starts eight bit clocks after toggle.
// R9: Right-justified: LSB is the last bit before the toggle.
// R10: Right-justified: leading unused bits are ignored.
// R11: Both words presented together with a one-cycle valid strobe.
// R12: Format input selects polarity, alignment and masking.
`timescale 1ns/1ps
module sair_receiver
  import sair_pkg::*;
#(
  parameter int unsigned WORD_W = SAIR_WORD_BITS
) (
  // System clock, reset, enable
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  // Format select
  input  wire sair_fmt_t         i_fmt,
  // Link pins
  input  wire logic              i_bclk,
  input  wire logic              i_lrclk,
  input  wire logic              i_sdata,
  // Sample output
  output logic [WORD_W-1:0]      o_left,
  output logic [WORD_W-1:0]      o_right,
  output logic                   o_valid
);
  typedef struct packed {
    logic [2:0]        sync;
    logic [WORD_W-1:0] left;
    logic [WORD_W-1:0] right;
    logic              valid;
  } sair_top_t;

  sair_top_t st_ff;
  sair_top_t nxt_st;

  sair_xfer_if #(.WORD_W(WORD_W)) xf ();

  // ==========================================================
  // Link domain capture
  sair_link_rx #(.WORD_W(WORD_W)) u_link (
    .i_bclk  (i_bclk),
    .i_rst_n (i_rst_n),
    .i_lrclk (i_lrclk),
    .i_sdata (i_sdata),
    .i_fmt   (i_fmt), // R12
    .xf      (xf.src)
  );

  // ==========================================================
  // Toggle crossing and frame handover
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync  = {st_ff.sync[1:0], xf.tgl};
    nxt_st.valid = 1'b0;
    if (st_ff.sync[2] != st_ff.sync[1]) begin
      nxt_st.left  = xf.left; // R11
      nxt_st.right = xf.right;
      nxt_st.valid = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else if (i_ce) begin
      st_ff <= nxt_st;
    end
  end

  assign o_left  = st_ff.left;
  assign o_right = st_ff.right;
  assign o_valid = st_ff.valid & i_ce;

  // ==========================================================
  // Checks
  property p_valid_one;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (o_valid && i_ce) |=> !st_ff.valid;
  endproperty
  a_valid_one: assert property (p_valid_one) // R11
    else $error("valid strobe longer than one cycle");

  c_valid: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_valid);
endmodule

// >>> testbench/sair_src_model.sv
// Audio source model driving three-wire serial frames
`timescale 1ns/1ps
module sair_src_model
  import sair_pkg::*;
(
  // Format and slot contents
  input  wire sair_fmt_t   i_fmt,
  input  wire logic [31:0] i_left,
  input  wire logic [31:0] i_right,
  // Link pins
  output logic             o_bclk,
  output logic             o_lrclk,
  output logic             o_sdata
);
  logic [63:0] frame;

  // ==========================================================
  // Free-running bit clock, 12 ns, data moved on falling edge
  initial begin
    o_bclk  = 1'b0;
    o_lrclk = 1'b1;
    o_sdata = 1'b0;
    frame   = '0;
    #3.3;
    forever begin
      for (int p = 0; p < 64; p++) begin
        if (p == 0) begin
          frame = {i_left, i_right};
        end
        o_bclk  = 1'b0;
        o_lrclk = (p >= 32) ^ (i_fmt != SAIR_FMT_STD);
        o_sdata = frame[63 - p];
        #6;
        o_bclk = 1'b1;
        #6;
      end
    end
  end
endmodule

// >>> testbench/sair_receiver_bench.sv
// Self-checking bench for the serial audio input receiver
`timescale 1ns/1ps
module sair_receiver_bench;
  import sair_pkg::*;
  logic        i_mclk;
  logic        i_rst_n;
  logic        i_ce;
  sair_fmt_t   i_fmt;
  logic        bclk;
  logic        lrclk;
  logic        sdata;
  logic [31:0] lslot;
  logic [31:0] rslot;
  logic [23:0] o_left;
  logic [23:0] o_right;
  logic        o_valid;
  int          err_total;
  int          tests_run;

  // ==========================================================
  // Clock and instances
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  sair_src_model sair_src_model_inst (
    .i_fmt   (i_fmt),
    .i_left  (lslot),
    .i_right (rslot),
    .o_bclk  (bclk),
    .o_lrclk (lrclk),
    .o_sdata (sdata)
  );

  sair_receiver #(.WORD_W(24)) sair_receiver_inst (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_fmt   (i_fmt),
    .i_bclk  (bclk),
    .i_lrclk (lrclk),
    .i_sdata (sdata),
    .o_left  (o_left),
    .o_right (o_right),
    .o_valid (o_valid)
  );

  // ==========================================================
  // Helpers
  function automatic logic [23:0] exp_word(input sair_fmt_t f,
                                           input logic [31:0] s);
    case (f)
      SAIR_FMT_STD: return s[30:7];
      SAIR_FMT_LJ:  return s[31:8];
      default:      return s[23:0];
    endcase
  endfunction

  task automatic test_done;
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [23:0] got,
                       input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_valid;
    int n;
    n = 0;
    @(negedge i_mclk);
    while (o_valid !== 1'b1) begin
      n++;
      if (n > 400) begin
        err_total++;
        $display("MISMATCH %0t no valid strobe", $time);
        test_done();
      end
      @(negedge i_mclk);
    end
  endtask

  // ==========================================================
  // Main sequence: every format, corner then random slots
  initial begin
    i_rst_n   = 1'b0;
    i_ce      = 1'b1;
    i_fmt     = SAIR_FMT_STD;
    lslot     = '0;
    rslot     = '0;
    err_total = 0;
    tests_run = 0;
    void'($urandom(32'h6E66ADCC));
    for (int f = 0; f < 3; f++) begin
      @(posedge i_mclk);
      i_rst_n <= 1'b0;
      i_fmt   <= sair_fmt_t'(f);
      repeat (4) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      @(negedge i_mclk);
      check("reset left", o_left, 24'h0);
      check("reset right", o_right, 24'h0);
      check("reset valid", {23'h0, o_valid}, 24'h0);
      for (int k = 0; k < 6; k++) begin
        @(posedge i_mclk);
        lslot <= (k == 0) ? 32'hFFFFFFFF : (k == 1) ? 32'h0 : $urandom;
        rslot <= (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF : $urandom;
        // Skip frames latched by the source before the slot change
        wait_valid();
        wait_valid();
        wait_valid();
        check("left", o_left, exp_word(i_fmt, lslot));
        check("right", o_right, exp_word(i_fmt, rslot));
        @(negedge i_mclk);
        check("strobe width", {23'h0, o_valid}, 24'h0);
      end
    end
    test_done();
  end
endmodule
